// ===== src/sst_pkg.sv
// Constants, register map and state type for the sequence trigger selector
package sst_pkg;
    // Bus and field widths
    localparam int DATA_W  = 32;
    localparam int ADDR_W  = 4;
    localparam int CODE_W  = 8;
    localparam int STATE_W = 3;
    localparam int AN_W    = 16;
    localparam int DELAY_W = 16;
    localparam int FBW_W   = 16;
    localparam int DIN_N   = 5;
    localparam int FBW_N   = 7;

    // Register word addresses
    localparam logic [3:0] REG_CTRL      = 4'h0;
    localparam logic [3:0] REG_LIMIT_ONE = 4'h1;
    localparam logic [3:0] REG_LIMIT_TWO = 4'h2;
    localparam logic [3:0] REG_DELAY     = 4'h3;
    localparam logic [3:0] REG_FIELDBUS  = 4'h4;
    localparam logic [3:0] REG_STATUS    = 4'h5;

    // Field positions
    localparam int CTRL_ADV_LSB     = 0;
    localparam int CTRL_JUMP_LSB    = 8;
    localparam int CTRL_TARGET_LSB  = 16;
    localparam int CTRL_RESTART_BIT = 31;
    localparam int LIMIT_LOW_LSB    = 0;
    localparam int LIMIT_HIGH_LSB   = 16;
    localparam int STAT_STATE_LSB   = 0;
    localparam int STAT_DLY_BIT     = 3;
    localparam int STAT_ADV_BIT     = 4;
    localparam int STAT_JUMP_BIT    = 5;
    localparam int STAT_DIN_LSB     = 6;

    // Reset values
    localparam logic [CODE_W-1:0]  CODE_RESET  = 8'h00;
    localparam logic [STATE_W-1:0] TGT_RESET   = 3'h0;
    localparam logic [AN_W-1:0]    LIMIT_RESET = 16'h0000;
    localparam logic [DELAY_W-1:0] DELAY_RESET = 16'h0000;
    localparam logic [FBW_W-1:0]   FBW_RESET   = 16'h0000;

    // Selection codes (51, 52, 53, 57, 61, 66, 70, 76)
    localparam logic [CODE_W-1:0] CODE_NEAR_REF  = 8'h33;
    localparam logic [CODE_W-1:0] CODE_ON_REF    = 8'h34;
    localparam logic [CODE_W-1:0] CODE_AI_DI5    = 8'h35;
    localparam logic [CODE_W-1:0] CODE_AI_DI4    = 8'h39;
    localparam logic [CODE_W-1:0] CODE_DLY_DI    = 8'h3D;
    localparam logic [CODE_W-1:0] CODE_DLY_AI    = 8'h42;
    localparam logic [CODE_W-1:0] CODE_FBW_FIRST = 8'h46;
    localparam logic [CODE_W-1:0] CODE_FBW_LAST  = 8'h4C;

    // Reference windows in percent of maximum reference
    localparam int NEAR_PCT = 4;
    localparam int ON_PCT   = 1;
    localparam int PCT_FULL = 100;

    // Delay timer resolution: one count is 0.1 s
    localparam int CLK_PERIOD_NS     = 10;
    localparam int DELAY_TICK_NS     = 100_000_000;
    localparam int DELAY_TICK_CYCLES = DELAY_TICK_NS / CLK_PERIOD_NS;

    // Sequence states, Gray coded along 1..8
    typedef enum logic [STATE_W-1:0] {
        SST_S1 = 3'h0, SST_S2 = 3'h1, SST_S3 = 3'h3, SST_S4 = 3'h2,
        SST_S5 = 3'h6, SST_S6 = 3'h7, SST_S7 = 3'h5, SST_S8 = 3'h4
    } sst_state_t;
endpackage : sst_pkg

// ===== src/sst_cond_if.sv
// Bundle of trigger conditions shared with the decoder; all registered except dly_done
`timescale 1ns/10ps
interface sst_cond_if;
    logic                      near_ref;
    logic                      on_ref;
    logic                      ai1_lt_lo1;
    logic                      ai1_lt_lo2;
    logic                      ai1_gt_hi1;
    logic                      ai1_gt_hi2;
    logic                      ai2_gt_hi2;
    logic                      ai2_lt_lo2;
    logic                      dly_done;
    logic [sst_pkg::DIN_N-1:0] din;
    logic [sst_pkg::FBW_N-1:0] fbw;

    modport src (output near_ref, on_ref, ai1_lt_lo1, ai1_lt_lo2,
                 ai1_gt_hi1, ai1_gt_hi2, ai2_gt_hi2, ai2_lt_lo2,
                 dly_done, din, fbw);
    modport sink (input near_ref, on_ref, ai1_lt_lo1, ai1_lt_lo2,
                  ai1_gt_hi1, ai1_gt_hi2, ai2_gt_hi2, ai2_lt_lo2,
                  dly_done, din, fbw);
endinterface : sst_cond_if

// ===== src/sst_cond_eval.sv
// Decoder from a selection code to one trigger condition
`timescale 1ns/10ps
module sst_cond_eval (
    input  wire logic [sst_pkg::CODE_W-1:0] code_in,
    sst_cond_if.sink                        cond,
    output logic                            hit_out
);
    logic [sst_pkg::CODE_W-1:0] off;
    logic [3:0]                 ai1_cmp;

    // First-input comparisons in low1, low2, high1, high2 order
    assign ai1_cmp = {cond.ai1_gt_hi2, cond.ai1_gt_hi1,
                      cond.ai1_lt_lo2, cond.ai1_lt_lo1};

    // Code table; codes outside the handled range never trigger
    always_comb begin
        hit_out = 1'b0;
        off     = sst_pkg::CODE_W'(8'h00);
        if (code_in == sst_pkg::CODE_NEAR_REF) begin
            hit_out = cond.near_ref;
        end else if (code_in == sst_pkg::CODE_ON_REF) begin
            hit_out = cond.on_ref;
        end else if (code_in >= sst_pkg::CODE_AI_DI5 &&
                     code_in <  sst_pkg::CODE_AI_DI4) begin
            off     = code_in - sst_pkg::CODE_AI_DI5;
            hit_out = ai1_cmp[off[1:0]] & cond.din[4];
        end else if (code_in >= sst_pkg::CODE_AI_DI4 &&
                     code_in <  sst_pkg::CODE_DLY_DI) begin
            off     = code_in - sst_pkg::CODE_AI_DI4;
            hit_out = ai1_cmp[off[1:0]] & cond.din[3];
        end else if (code_in >= sst_pkg::CODE_DLY_DI &&
                     code_in <  sst_pkg::CODE_DLY_AI) begin
            off     = code_in - sst_pkg::CODE_DLY_DI;
            hit_out = cond.dly_done & cond.din[off[2:0]];
        end else if (code_in >= sst_pkg::CODE_DLY_AI &&
                     code_in <  sst_pkg::CODE_FBW_FIRST) begin
            off = code_in - sst_pkg::CODE_DLY_AI;
            case (off[1:0])
                2'h0:    hit_out = cond.dly_done & cond.ai2_gt_hi2;
                2'h1:    hit_out = cond.dly_done & cond.ai2_lt_lo2;
                2'h2:    hit_out = cond.dly_done & cond.ai1_gt_hi1;
                default: hit_out = cond.dly_done & cond.ai1_lt_lo1;
            endcase
        end else if (code_in >= sst_pkg::CODE_FBW_FIRST &&
                     code_in <= sst_pkg::CODE_FBW_LAST) begin
            off     = code_in - sst_pkg::CODE_FBW_FIRST;
            hit_out = cond.fbw[off[2:0]];
        end
    end
endmodule : sst_cond_eval

// ===== src/sst_trigger_select.sv
// Trigger source selection for state one of the sequence machine
//
// Notes on behaviour
// - Code 51 requests a change when speed is within 4% of max ref.
// - Code 52 requests a change when speed is within 1% of max ref.
// - Codes 53..56 compare input one to low1/low2/high1/high2, and input five.
// - Codes 57..60 are the same comparisons gated by input four.
// - Codes 61..65 need the delay elapsed and input one..five active.
// - Codes 66..69 need the delay elapsed and one analog comparison.
// - Codes 70..76 take bits 0..6 of the fieldbus value word.
// - A jump trigger wins over the advance trigger when both hold.
`timescale 1ns/10ps
module sst_trigger_select #(
    parameter int TICK_CYCLES = sst_pkg::DELAY_TICK_CYCLES
) (
    input  wire logic                            clk_sys_in,
    input  wire logic                            rst_b_in,
    input  wire logic [sst_pkg::ADDR_W-1:0]      addr_in,
    input  wire logic [sst_pkg::DATA_W-1:0]      wdata_in,
    input  wire logic                            wr_in,
    input  wire logic                            rd_in,
    output logic      [sst_pkg::DATA_W-1:0]      rdata_out,
    input  wire logic [sst_pkg::DIN_N-1:0]       digital_input_in,
    input  wire logic [sst_pkg::AN_W-1:0]        analog_input_one_in,
    input  wire logic [sst_pkg::AN_W-1:0]        analog_input_two_in,
    input  wire logic [sst_pkg::AN_W-1:0]        speed_in,
    input  wire logic [sst_pkg::AN_W-1:0]        reference_in,
    input  wire logic [sst_pkg::AN_W-1:0]        max_reference_in,
    output logic      [sst_pkg::STATE_W-1:0]     seq_state_out,
    output logic                                 advance_out,
    output logic                                 jump_out,
    output logic                                 delay_elapsed_out
);
    localparam int PROD_W = sst_pkg::AN_W + 7;
    localparam int TICK_W = $clog2(TICK_CYCLES + 1);
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

    // Software registers
    logic [sst_pkg::CODE_W-1:0]  advance_trigger_select;
    logic [sst_pkg::CODE_W-1:0]  jump_trigger_select;
    logic [sst_pkg::STATE_W-1:0] jump_target;
    logic                        restart;
    logic [sst_pkg::AN_W-1:0]    low_limit_one;
    logic [sst_pkg::AN_W-1:0]    high_limit_one;
    logic [sst_pkg::AN_W-1:0]    low_limit_two;
    logic [sst_pkg::AN_W-1:0]    high_limit_two;
    logic [sst_pkg::DELAY_W-1:0] state_change_delay_time;
    logic [sst_pkg::FBW_W-1:0]   fieldbus_value_word;

    // Sequencer and timer state
    sst_pkg::sst_state_t         state;
    sst_pkg::sst_state_t         next_state;
    logic                        entry;
    logic [TICK_W-1:0]           tick_cnt;
    logic [sst_pkg::DELAY_W-1:0] delay_cnt;
    logic                        adv_hit;
    logic                        jump_hit;

    // Input synchronisers and reference error
    logic [sst_pkg::DIN_N-1:0]   din_meta;
    logic [sst_pkg::DIN_N-1:0]   din_sync;
    logic [sst_pkg::AN_W-1:0]    ref_err;
    logic [PROD_W-1:0]           err_scaled;
    logic [PROD_W-1:0]           near_lim;
    logic [PROD_W-1:0]           on_lim;

    sst_cond_if cond ();

    // Write decode; restart is a one-cycle action, not stored
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            advance_trigger_select  <= sst_pkg::CODE_RESET;
            jump_trigger_select     <= sst_pkg::CODE_RESET;
            jump_target             <= sst_pkg::TGT_RESET;
            restart                 <= 1'b0;
            low_limit_one           <= sst_pkg::LIMIT_RESET;
            high_limit_one          <= sst_pkg::LIMIT_RESET;
            low_limit_two           <= sst_pkg::LIMIT_RESET;
            high_limit_two          <= sst_pkg::LIMIT_RESET;
            state_change_delay_time <= sst_pkg::DELAY_RESET;
            fieldbus_value_word     <= sst_pkg::FBW_RESET;
        end else begin
            restart <= wr_in && addr_in == sst_pkg::REG_CTRL &&
                       wdata_in[sst_pkg::CTRL_RESTART_BIT];
            if (wr_in) begin
                case (addr_in)
                    sst_pkg::REG_CTRL: begin
                        advance_trigger_select <= wdata_in[
                            sst_pkg::CTRL_ADV_LSB +: sst_pkg::CODE_W];
                        jump_trigger_select <= wdata_in[
                            sst_pkg::CTRL_JUMP_LSB +: sst_pkg::CODE_W];
                        jump_target <= wdata_in[
                            sst_pkg::CTRL_TARGET_LSB +: sst_pkg::STATE_W];
                    end
                    sst_pkg::REG_LIMIT_ONE: begin
                        low_limit_one  <= wdata_in[
                            sst_pkg::LIMIT_LOW_LSB +: sst_pkg::AN_W];
                        high_limit_one <= wdata_in[
                            sst_pkg::LIMIT_HIGH_LSB +: sst_pkg::AN_W];
                    end
                    sst_pkg::REG_LIMIT_TWO: begin
                        low_limit_two  <= wdata_in[
                            sst_pkg::LIMIT_LOW_LSB +: sst_pkg::AN_W];
                        high_limit_two <= wdata_in[
                            sst_pkg::LIMIT_HIGH_LSB +: sst_pkg::AN_W];
                    end
                    sst_pkg::REG_DELAY: begin
                        state_change_delay_time <=
                            wdata_in[sst_pkg::DELAY_W-1:0];
                    end
                    sst_pkg::REG_FIELDBUS: begin
                        fieldbus_value_word <= wdata_in[sst_pkg::FBW_W-1:0];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Read mux; data stands one cycle after the strobe, else zero
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            rdata_out <= '0;
        end else begin
            rdata_out <= '0;
            if (rd_in) begin
                case (addr_in)
                    sst_pkg::REG_CTRL: begin
                        rdata_out[sst_pkg::CTRL_ADV_LSB +: sst_pkg::CODE_W]
                            <= advance_trigger_select;
                        rdata_out[sst_pkg::CTRL_JUMP_LSB +: sst_pkg::CODE_W]
                            <= jump_trigger_select;
                        rdata_out[sst_pkg::CTRL_TARGET_LSB +:
                                  sst_pkg::STATE_W] <= jump_target;
                    end
                    sst_pkg::REG_LIMIT_ONE: begin
                        rdata_out <= {high_limit_one, low_limit_one};
                    end
                    sst_pkg::REG_LIMIT_TWO: begin
                        rdata_out <= {high_limit_two, low_limit_two};
                    end
                    sst_pkg::REG_DELAY: begin
                        rdata_out[sst_pkg::DELAY_W-1:0] <=
                            state_change_delay_time;
                    end
                    sst_pkg::REG_FIELDBUS: begin
                        rdata_out[sst_pkg::FBW_W-1:0] <= fieldbus_value_word;
                    end
                    sst_pkg::REG_STATUS: begin
                        rdata_out[sst_pkg::STAT_STATE_LSB +:
                                  sst_pkg::STATE_W] <= seq_state_out;
                        rdata_out[sst_pkg::STAT_DLY_BIT]  <= cond.dly_done;
                        rdata_out[sst_pkg::STAT_ADV_BIT]  <= adv_hit;
                        rdata_out[sst_pkg::STAT_JUMP_BIT] <= jump_hit;
                        rdata_out[sst_pkg::STAT_DIN_LSB +: sst_pkg::DIN_N]
                            <= din_sync;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Two-stage synchroniser per digital input pin
    genvar gi;
    generate
        for (gi = 0; gi < sst_pkg::DIN_N; gi++) begin : g_din
            always_ff @(posedge clk_sys_in) begin
                if (!rst_b_in) begin
                    din_meta[gi] <= 1'b0;
                    din_sync[gi] <= 1'b0;
                end else begin
                    din_meta[gi] <= digital_input_in[gi];
                    din_sync[gi] <= din_meta[gi];
                end
            end
        end
    endgenerate

    // Reference error scaled to percent against the windows
    assign ref_err    = (speed_in >= reference_in) ?
                        speed_in - reference_in : reference_in - speed_in;
    assign err_scaled = PROD_W'(ref_err) * PROD_W'(sst_pkg::PCT_FULL);
    assign near_lim   = PROD_W'(max_reference_in) *
                        PROD_W'(sst_pkg::NEAR_PCT);
    assign on_lim     = PROD_W'(max_reference_in) * PROD_W'(sst_pkg::ON_PCT);

    // Registered comparator flags for the decoders
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            cond.near_ref   <= 1'b0;
            cond.on_ref     <= 1'b0;
            cond.ai1_lt_lo1 <= 1'b0;
            cond.ai1_lt_lo2 <= 1'b0;
            cond.ai1_gt_hi1 <= 1'b0;
            cond.ai1_gt_hi2 <= 1'b0;
            cond.ai2_gt_hi2 <= 1'b0;
            cond.ai2_lt_lo2 <= 1'b0;
        end else begin
            cond.near_ref   <= err_scaled <= near_lim;
            cond.on_ref     <= err_scaled <= on_lim;
            cond.ai1_lt_lo1 <= analog_input_one_in < low_limit_one;
            cond.ai1_lt_lo2 <= analog_input_one_in < low_limit_two;
            cond.ai1_gt_hi1 <= analog_input_one_in > high_limit_one;
            cond.ai1_gt_hi2 <= analog_input_one_in > high_limit_two;
            cond.ai2_gt_hi2 <= analog_input_two_in > high_limit_two;
            cond.ai2_lt_lo2 <= analog_input_two_in < low_limit_two;
        end
    end

    assign cond.din      = din_sync;
    assign cond.fbw      = fieldbus_value_word[sst_pkg::FBW_N-1:0];
    assign cond.dly_done = delay_cnt >= state_change_delay_time;

    sst_cond_eval u_adv (
        .code_in (advance_trigger_select),
        .cond    (cond),
        .hit_out (adv_hit)
    );

    sst_cond_eval u_jump (
        .code_in (jump_trigger_select),
        .cond    (cond),
        .hit_out (jump_hit)
    );

    // Next state: jump before advance, evaluated only in state one
    always_comb begin
        next_state = state;
        entry      = 1'b0;
        if (restart) begin
            next_state = sst_pkg::SST_S1;
            entry      = 1'b1;
        end else if (state == sst_pkg::SST_S1) begin
            if (jump_hit) begin
                next_state = sst_pkg::sst_state_t'(
                    jump_target ^ (jump_target >> 1));
                entry      = 1'b1;
            end else if (adv_hit) begin
                next_state = sst_pkg::SST_S2;
            end
        end
    end

    // Sequence state and its numeric copy for the outputs
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            state         <= sst_pkg::SST_S1;
            seq_state_out <= sst_pkg::TGT_RESET;
            advance_out   <= 1'b0;
            jump_out      <= 1'b0;
        end else begin
            state       <= next_state;
            advance_out <= !restart && state == sst_pkg::SST_S1 &&
                           !jump_hit && adv_hit;
            jump_out    <= !restart && state == sst_pkg::SST_S1 &&
                           jump_hit;
            if (restart) begin
                seq_state_out <= sst_pkg::TGT_RESET;
            end else if (state == sst_pkg::SST_S1 && jump_hit) begin
                seq_state_out <= jump_target;
            end else if (state == sst_pkg::SST_S1 && adv_hit) begin
                seq_state_out <= 3'h1;
            end
        end
    end

    // Delay timer in 0.1 s counts, cleared on every entry into state one
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            tick_cnt          <= '0;
            delay_cnt         <= '0;
            delay_elapsed_out <= 1'b0;
        end else begin
            delay_elapsed_out <= cond.dly_done && state == sst_pkg::SST_S1;
            if (entry || state != sst_pkg::SST_S1) begin
                tick_cnt  <= '0;
                delay_cnt <= '0;
            end else if (tick_cnt == TICK_LAST) begin
                tick_cnt <= '0;
                if (!cond.dly_done) begin
                    delay_cnt <= delay_cnt + 1'b1;
                end
            end else begin
                tick_cnt <= tick_cnt + 1'b1;
            end
        end
    end
endmodule : sst_trigger_select

// ===== testbench/sst_trigger_select_asserts.sv
// Port checker for the sequence trigger selector
`timescale 1ns/10ps
module sst_trigger_select_asserts (
    input  wire logic [sst_pkg::STATE_W-1:0] seq_state_out,
    input  wire logic                        clk_sys_in,
    input  wire logic                        rst_b_in,
    input  wire logic [sst_pkg::ADDR_W-1:0]  addr_in,
    input  wire logic [sst_pkg::DATA_W-1:0]  wdata_in,
    input  wire logic                        wr_in,
    input  wire logic                        rd_in,
    input  wire logic [sst_pkg::DATA_W-1:0]  rdata_out,
    input  wire logic                        advance_out,
    input  wire logic                        jump_out
);
    logic [2:0] tgt;
    logic       rst_wr;

    // Jump target as last written to the control word
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in)
            tgt <= 3'h0;
        else if (wr_in && addr_in == sst_pkg::REG_CTRL)
            tgt <= wdata_in[18:16];
    end
    assign rst_wr = wr_in && addr_in == sst_pkg::REG_CTRL && wdata_in[31];

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_b_in);

    adv_to_two_a: assert property (advance_out |->
        seq_state_out == 3'h1 && $past(seq_state_out) == 3'h0)
        else $error("advance not from state one to two");
    jump_target_a: assert property (jump_out |->
        seq_state_out == $past(tgt) && $past(seq_state_out) == 3'h0)
        else $error("jump to wrong state");
    one_winner_a: assert property (!(advance_out && jump_out))
        else $error("advance and jump together");
    hold_other_a: assert property ($past(seq_state_out) != 3'h0
        && !$past(rst_wr, 2) |-> $stable(seq_state_out))
        else $error("state left without restart");
    restart_a: assert property ($past(rst_wr, 2) |-> seq_state_out == 3'h0)
        else $error("restart did not reach state one");
    reset_exit_a: assert property ($rose(rst_b_in) |-> seq_state_out == 3'h0
        && !advance_out && !jump_out && rdata_out == 32'h0)
        else $error("outputs not cleared by reset");
    rd_idle_a: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
        else $error("read data outside read slot");
    status_state_a: assert property ($past(rd_in)
        && $past(addr_in) == sst_pkg::REG_STATUS
        |-> rdata_out[2:0] == $past(seq_state_out))
        else $error("status state field wrong");
endmodule : sst_trigger_select_asserts

bind sst_trigger_select sst_trigger_select_asserts i_sst_asserts (
    .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .seq_state_out(seq_state_out),
    .advance_out(advance_out), .jump_out(jump_out));

// ===== testbench/sst_drive_model.sv
// Drive side model: digital pins, analog inputs and speed feedback
`timescale 1ns/10ps
module sst_drive_model (
    input  wire logic        clk_sys_in,
    output logic      [4:0]  din_out,
    output logic      [15:0] an_one_out,
    output logic      [15:0] an_two_out,
    output logic      [15:0] speed_out,
    output logic      [15:0] ref_out,
    output logic      [15:0] max_ref_out
);
    // Reference and full scale stay fixed for the whole run
    assign ref_out     = 16'h4000;
    assign max_ref_out = 16'h2710;

    // Idle levels at time zero
    initial begin
        din_out    = 5'h00;
        an_one_out = 16'h2800;
        an_two_out = 16'h2800;
        speed_out  = 16'h0000;
    end

    // New pin levels land just after a rising edge
    task automatic drive(input logic [1:0] sel, input logic [15:0] val,
                         input logic [4:0] bits);
        @(posedge clk_sys_in);
        din_out <= bits;
        case (sel)
            2'h0: an_one_out <= val;
            2'h1: an_two_out <= val;
            default: speed_out <= val;
        endcase
    endtask : drive
endmodule : sst_drive_model

// ===== testbench/sst_trigger_select_tb.sv
// Self-checking bench for the sequence trigger selector
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin \
    num_errors++; \
    $display("Error %s expected %0h seen %0h", n, e, g); end end
module sst_trigger_select_tb;
    logic        clk_sys_in, rst_b_in, wr_in, rd_in;
    logic        advance_out, jump_out, delay_elapsed_out;
    logic [3:0]  addr_in;
    logic [31:0] wdata_in, rdata_out, rv;
    logic [2:0]  seq_state_out;
    logic [4:0]  din;
    logic [15:0] an1, an2, spd, rf, mx;
    int          num_errors, n_checks, adv_cnt, jmp_cnt, a0, j0;
    logic [15:0] off_t [4] = '{16'h1800, 16'h2800, 16'h2800, 16'h3800};
    logic [15:0] on_t  [4] = '{16'h0800, 16'h1800, 16'h3800, 16'h4800};

    sst_trigger_select #(.TICK_CYCLES(4)) i_sst_trigger_select (
        .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .digital_input_in(din),
        .analog_input_one_in(an1), .analog_input_two_in(an2),
        .speed_in(spd), .reference_in(rf), .max_reference_in(mx),
        .seq_state_out(seq_state_out), .advance_out(advance_out),
        .jump_out(jump_out), .delay_elapsed_out(delay_elapsed_out));
    sst_drive_model i_sst_drive_model (.clk_sys_in(clk_sys_in),
        .din_out(din), .an_one_out(an1), .an_two_out(an2),
        .speed_out(spd), .ref_out(rf), .max_ref_out(mx));

    // Clock at 100 MHz
    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end

    // Pulse counters, sampled away from the launching edge
    always @(negedge clk_sys_in) begin
        if (advance_out === 1'b1) adv_cnt++;
        if (jump_out === 1'b1) jmp_cnt++;
    end

    task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge clk_sys_in);
        wr_in <= 1'b0;
    endtask : bus_wr

    task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_sys_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge clk_sys_in);
        rd_in <= 1'b0;
        @(negedge clk_sys_in);
        d = rdata_out;
    endtask : bus_rd

    // Condition off past restart, then on
    task automatic run_code(input int c);
        logic [1:0]  sel;
        logic [15:0] off_v, on_v;
        logic [4:0]  bits;
        int          k, pre;
        k = (c - 53) % 4;
        sel = 2'h0;
        bits = 5'h00;
        pre = 6;
        off_v = 16'h2800;
        on_v = 16'h2800;
        if (c < 53) begin
            sel   = 2'h2;
            off_v = (c == 51) ? 16'h4191 : 16'h4065;
            on_v  = (c == 51) ? 16'h4190 : 16'h4064;
        end else if (c < 61) begin
            off_v = off_t[k];
            on_v  = on_t[k];
            bits  = (c < 57) ? 5'h10 : 5'h08;
        end else if (c < 66) begin
            bits = 5'h01 << (c - 61);
            pre  = 4;
        end else if (c < 70) begin
            k     = (c == 66) ? 3 : (c == 67) ? 1 : (c == 68) ? 2 : 0;
            sel   = (c < 68) ? 2'h1 : 2'h0;
            off_v = off_t[k];
            on_v  = on_t[k];
            pre   = 12;
        end else begin
            sel   = 2'h3;
            on_v  = 16'h0001 << (c - 70);
            off_v = ~on_v & 16'h007F;
        end
        if (sel == 2'h3) bus_wr(sst_pkg::REG_FIELDBUS, {16'h0, off_v});
        else i_sst_drive_model.drive(sel, off_v, bits);
        bus_wr(sst_pkg::REG_CTRL, {24'h800000, c[7:0]});
        a0 = adv_cnt;
        repeat (3) @(negedge clk_sys_in);
        `CHK("elapsed after restart", 1'b0, delay_elapsed_out)
        repeat (pre - 2) @(negedge clk_sys_in);
        `CHK("early advance", a0, adv_cnt)
        if (sel == 2'h3) bus_wr(sst_pkg::REG_FIELDBUS, {16'h0, on_v});
        else i_sst_drive_model.drive(sel, on_v, bits);
        for (k = 0; k < 24 && adv_cnt == a0; k++) @(negedge clk_sys_in);
        `CHK("advance count", a0 + 1, adv_cnt)
        `CHK("state after advance", 3'h1, seq_state_out)
    endtask : run_code

    task automatic print_verdict;
        $display("Checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : print_verdict

    // Watchdog
    initial begin
        #500_000;
        num_errors++;
        print_verdict();
    end

    // Main sequence
    initial begin
        rst_b_in = 1'b0;
        wr_in = 1'b0;
        rd_in = 1'b0;
        addr_in = 4'h0;
        wdata_in = 32'h0;
        repeat (4) @(posedge clk_sys_in);
        rst_b_in <= 1'b1;
        for (int a = 0; a < 7; a++) begin
            bus_rd(4'(a), rv);
            `CHK("reset word", (a == 5) ? 32'h8 : 32'h0, rv)
        end
        bus_wr(sst_pkg::REG_LIMIT_ONE, 32'h3000_1000);
        bus_wr(sst_pkg::REG_LIMIT_TWO, 32'h4000_2000);
        bus_wr(sst_pkg::REG_DELAY, 32'h2);
        bus_wr(4'h9, 32'hFFFF_FFFF);
        bus_rd(sst_pkg::REG_LIMIT_ONE, rv);
        `CHK("limit one word", 32'h3000_1000, rv)
        for (int c = 51; c < 53; c++) run_code(c);
        for (int c = 53; c < 57; c++) run_code(c);
        for (int c = 57; c < 61; c++) run_code(c);
        for (int c = 61; c < 66; c++) run_code(c);
        for (int c = 66; c < 70; c++) run_code(c);
        for (int c = 70; c < 77; c++) run_code(c);
        // Both triggers, jump to state six wins
        bus_wr(sst_pkg::REG_FIELDBUS, 32'h0);
        bus_wr(sst_pkg::REG_CTRL, 32'h8005_4746);
        a0 = adv_cnt;
        j0 = jmp_cnt;
        bus_wr(sst_pkg::REG_FIELDBUS, 32'h3);
        for (int i = 0; i < 24 && jmp_cnt == j0; i++) @(negedge clk_sys_in);
        `CHK("jump count", j0 + 1, jmp_cnt)
        `CHK("advance count", a0, adv_cnt)
        `CHK("jump state", 3'h5, seq_state_out)
        bus_rd(sst_pkg::REG_STATUS, rv);
        `CHK("status state", 3'h5, rv[2:0])
        bus_rd(sst_pkg::REG_CTRL, rv);
        `CHK("control word", 32'h0005_4746, rv)
        bus_wr(sst_pkg::REG_CTRL, 32'h8000_0000);
        repeat (2) @(negedge clk_sys_in);
        `CHK("state after restart", 3'h0, seq_state_out)
        print_verdict();
    end
endmodule : sst_trigger_select_tb
